// >>> core/tcma_pkg.sv
// Package for the temperature conversion mode and alert logic
package tcma_pkg;
	localparam int DW = 16;
	// Register offsets
	localparam logic [7:0] REG_RESULT = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h01;
	localparam logic [7:0] REG_HIGH   = 8'h02;
	localparam logic [7:0] REG_LOW    = 8'h03;
	// Configuration field positions
	localparam int CFG_HIGH_BIT  = 15;
	localparam int CFG_LOW_BIT   = 14;
	localparam int CFG_READY_BIT = 13;
	localparam int CFG_MODE_LSB  = 10;
	localparam int CFG_CYC_LSB   = 7;
	localparam int CFG_AVG_LSB   = 5;
	localparam int CFG_HYST_BIT  = 4;
	localparam int CFG_POL_BIT   = 3;
	localparam int CFG_DRP_BIT   = 2;
	// Conversion modes
	localparam logic [1:0] MODE_CONT_A = 2'h0;
	localparam logic [1:0] MODE_SHUT   = 2'h1;
	localparam logic [1:0] MODE_CONT_B = 2'h2;
	localparam logic [1:0] MODE_SINGLE = 2'h3;
	// Reset values
	localparam logic [15:0] RESULT_RST = 16'h8000;
	localparam logic [15:0] HIGH_RST   = 16'h6000;
	localparam logic [15:0] LOW_RST    = 16'h8000;
	// Timing
	localparam longint CLK_PERIOD_NS = 10;
	localparam longint T_CYCLE_TIME_FIELD_NS     = 15_500_000;
	localparam longint T_STEP_NS     = 125_000_000;
	localparam int CYCLE_TIME_FIELD_CYCLES = int'(T_CYCLE_TIME_FIELD_NS / CLK_PERIOD_NS);
	localparam int STEP_CYCLES = int'(T_STEP_NS / CLK_PERIOD_NS);

	typedef enum logic [1:0] {PH_SHUTDOWN, PH_CONVERT, PH_STANDBY} tcma_phase_t;

	typedef struct packed {
		logic       ready_to_pin_select;
		logic       alert_polarity_bit;
		logic       hysteresis_mode_select;
		logic [1:0] averaging_count_field;
		logic [2:0] cycle_time_field;
		logic [1:0] conversion_mode_field;
	} tcma_cfg_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} tcma_bus_t;

	typedef struct packed {
		tcma_phase_t        phase;
		tcma_cfg_t          cfg;
		logic [15:0]        result;
		logic [15:0]        high_lim;
		logic [15:0]        low_lim;
		logic               high_flag;
		logic               low_flag;
		logic               data_ready;
		logic               alert_latch;
		logic               single_shot;
		logic [31:0]        cnt;
		logic [6:0]         avg_cnt;
		logic signed [21:0] acc;
		logic [15:0]        temp_s1;
		logic [15:0]        temp_s2;
		logic [15:0]        rdata;
		logic               alert_pin;
		logic               frontend_on;
	} tcma_state_t;

	// Averaging field to shift amount (1, 8, 32, 64 samples)
	function automatic logic [2:0] avg_shift(input logic [1:0] f);
		case (f)
			2'h0: avg_shift = 3'h0;
			2'h1: avg_shift = 3'h3;
			2'h2: avg_shift = 3'h5;
			default: avg_shift = 3'h6;
		endcase
	endfunction

	// Signed 16-bit greater-than
	function automatic logic s_gt(input logic [15:0] a, input logic [15:0] b);
		s_gt = $signed(a) > $signed(b);
	endfunction
endpackage

// >>> core/tcma_core.sv
// Conversion mode sequencing and limit alert logic
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Modes 00 and 10 convert continuously, loading result each conversion end.
// - Reading configuration or result clears the conversion-complete flag.
// - Ready-to-pin select drives alert pin from conversion-complete flag.
// - Writing mode 01 aborts conversion at once and powers down.
// - Writing mode 11 runs one conversion, then returns to shutdown.
// - Single shot has no standby; length set only by averaging.
// - Single shot end sets conversion-complete and updates alert flags.
// - Start-up mode single shot becomes shutdown instead.
// - Every final result is compared with both limits, flags updated.
// - Window mode: result above high limit sets high flag.
// - Window mode: result below low limit sets low flag.
// - Window mode: configuration read clears both limit flags.
// - Window mode: pin asserts on flag, cleared by configuration read or alert response.
// - Alert pin active level follows the polarity bit in both modes.
// - Hysteresis mode: above high sets high flag, below low clears it.
// - Hysteresis mode: low flag disabled, reads zero.
// - Hysteresis mode: reads leave flags; changes only at conversion end.
// - Hysteresis mode: pin tracks high flag, immune to reads and responses.
// - Result and limits are signed 16-bit values compared signed.
module tcma_core
	import tcma_pkg::*;
#(
	parameter int CYCLE_TIME_FIELD_CYC = CYCLE_TIME_FIELD_CYCLES,
	parameter int STEP_CYC = STEP_CYCLES
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire tcma_bus_t   i_bus,
	input  wire tcma_cfg_t   i_por_cfg,
	input  wire logic [15:0] i_temp_code,
	input  wire logic        i_alert_resp,
	output logic      [15:0] o_rdata,
	output logic             o_alert,
	output logic             o_frontend_on
);

	// ****************************************
	// State
	// ****************************************
	tcma_state_t s_ff;
	tcma_state_t nxt_s;
	tcma_state_t rst_s;

	logic               sample_end;
	logic               final_end;
	logic [2:0]         shift;
	logic [6:0]         avg_last;
	logic signed [21:0] acc_sum;
	logic [15:0]        avg_val;
	logic               cfg_wr;
	logic               cfg_rd;
	logic               res_rd;
	logic               above;
	logic               below;
	logic               active;
	tcma_cfg_t          wcfg;

	assign o_rdata       = s_ff.rdata;
	assign o_alert       = s_ff.alert_pin;
	assign o_frontend_on = s_ff.frontend_on;

	// ****************************************
	// Reset image
	// ****************************************
	always_comb begin
		rst_s = '0;
		rst_s.cfg = i_por_cfg;
		rst_s.result = RESULT_RST;
		rst_s.high_lim = HIGH_RST;
		rst_s.low_lim = LOW_RST;
		rst_s.phase = PH_CONVERT;
		if (i_por_cfg.conversion_mode_field == MODE_SINGLE) begin
			rst_s.cfg.conversion_mode_field = MODE_SHUT;
		end
		if (rst_s.cfg.conversion_mode_field == MODE_SHUT) begin
			rst_s.phase = PH_SHUTDOWN;
		end
		rst_s.frontend_on = (rst_s.phase == PH_CONVERT);
		rst_s.alert_pin = ~i_por_cfg.alert_polarity_bit;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_s = s_ff;
		nxt_s.temp_s1 = i_temp_code;
		nxt_s.temp_s2 = s_ff.temp_s1;
		nxt_s.rdata = '0;

		cfg_wr = i_bus.wr && (i_bus.addr == REG_CONFIG);
		cfg_rd = i_bus.rd && (i_bus.addr == REG_CONFIG);
		res_rd = i_bus.rd && (i_bus.addr == REG_RESULT);
		wcfg = {i_bus.wdata[CFG_DRP_BIT], i_bus.wdata[CFG_POL_BIT],
			i_bus.wdata[CFG_HYST_BIT], i_bus.wdata[CFG_AVG_LSB+:2],
			i_bus.wdata[CFG_CYC_LSB+:3], i_bus.wdata[CFG_MODE_LSB+:2]};

		// Averaging of samples over the active conversion time
		shift = avg_shift(s_ff.cfg.averaging_count_field);
		avg_last = 7'((7'h1 << shift) - 7'h1);
		sample_end = (s_ff.phase == PH_CONVERT) && (s_ff.cnt == 32'(CYCLE_TIME_FIELD_CYC - 1));
		final_end = sample_end && (s_ff.avg_cnt == avg_last);
		acc_sum = s_ff.acc + 22'(signed'(s_ff.temp_s2));
		avg_val = 16'(acc_sum >>> shift);
		above = s_gt(avg_val, s_ff.high_lim);
		below = s_gt(s_ff.low_lim, avg_val);

		// Read data, one cycle later
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				REG_RESULT: nxt_s.rdata = s_ff.result;
				REG_HIGH: nxt_s.rdata = s_ff.high_lim;
				REG_LOW: nxt_s.rdata = s_ff.low_lim;
				REG_CONFIG: begin
					nxt_s.rdata[CFG_HIGH_BIT] = s_ff.high_flag;
					nxt_s.rdata[CFG_LOW_BIT] = s_ff.low_flag;
					nxt_s.rdata[CFG_READY_BIT] = s_ff.data_ready;
					nxt_s.rdata[CFG_MODE_LSB+:2] = s_ff.cfg.conversion_mode_field;
					nxt_s.rdata[CFG_CYC_LSB+:3] = s_ff.cfg.cycle_time_field;
					nxt_s.rdata[CFG_AVG_LSB+:2] = s_ff.cfg.averaging_count_field;
					nxt_s.rdata[CFG_HYST_BIT] = s_ff.cfg.hysteresis_mode_select;
					nxt_s.rdata[CFG_POL_BIT] = s_ff.cfg.alert_polarity_bit;
					nxt_s.rdata[CFG_DRP_BIT] = s_ff.cfg.ready_to_pin_select;
				end
				default: nxt_s.rdata = '0;
			endcase
		end

		// Conversion sequencing
		unique case (s_ff.phase)
			PH_SHUTDOWN: begin
				nxt_s.cnt = '0;
			end
			PH_CONVERT: begin
				nxt_s.cnt = s_ff.cnt + 32'h1;
				if (sample_end) begin
					nxt_s.cnt = '0;
					nxt_s.acc = acc_sum;
					nxt_s.avg_cnt = s_ff.avg_cnt + 7'h1;
				end
				if (final_end) begin
					nxt_s.acc = '0;
					nxt_s.avg_cnt = '0;
					nxt_s.result = avg_val;
					if (s_ff.single_shot) begin
						nxt_s.phase = PH_SHUTDOWN;
						nxt_s.single_shot = 1'b0;
						nxt_s.cfg.conversion_mode_field = MODE_SHUT;
					end else if (s_ff.cfg.cycle_time_field != 3'h0) begin
						nxt_s.phase = PH_STANDBY;
						nxt_s.cnt = 32'(s_ff.cfg.cycle_time_field) * 32'(STEP_CYC) - 32'h1;
					end
				end
			end
			PH_STANDBY: begin
				nxt_s.cnt = s_ff.cnt - 32'h1;
				if (s_ff.cnt == 32'h0) begin
					nxt_s.phase = PH_CONVERT;
				end
			end
			default: nxt_s.phase = PH_SHUTDOWN;
		endcase

		// Register writes
		if (i_bus.wr) begin
			if (i_bus.addr == REG_HIGH) begin
				nxt_s.high_lim = i_bus.wdata;
			end
			if (i_bus.addr == REG_LOW) begin
				nxt_s.low_lim = i_bus.wdata;
			end
		end
		if (cfg_wr) begin
			nxt_s.cfg = wcfg;
			if (wcfg.conversion_mode_field == MODE_SHUT) begin
				nxt_s.phase = PH_SHUTDOWN;
				nxt_s.single_shot = 1'b0;
				nxt_s.cnt = '0;
				nxt_s.acc = '0;
				nxt_s.avg_cnt = '0;
			end else if (wcfg.conversion_mode_field == MODE_SINGLE) begin
				nxt_s.phase = PH_CONVERT;
				nxt_s.single_shot = 1'b1;
				nxt_s.cnt = '0;
				nxt_s.acc = '0;
				nxt_s.avg_cnt = '0;
			end else if (s_ff.phase == PH_SHUTDOWN || s_ff.single_shot) begin
				nxt_s.phase = PH_CONVERT;
				nxt_s.single_shot = 1'b0;
				nxt_s.cnt = '0;
				nxt_s.acc = '0;
				nxt_s.avg_cnt = '0;
			end
		end

		// Conversion-complete flag, set wins
		if (cfg_rd || res_rd) begin
			nxt_s.data_ready = 1'b0;
		end
		if (final_end) begin
			nxt_s.data_ready = 1'b1;
		end

		// Limit flags
		if (!s_ff.cfg.hysteresis_mode_select) begin
			if (cfg_rd) begin
				nxt_s.high_flag = 1'b0;
				nxt_s.low_flag = 1'b0;
			end
			if (cfg_rd || i_alert_resp) begin
				nxt_s.alert_latch = 1'b0;
			end
			if (final_end && above) begin
				nxt_s.high_flag = 1'b1;
				nxt_s.alert_latch = 1'b1;
			end
			if (final_end && below) begin
				nxt_s.low_flag = 1'b1;
				nxt_s.alert_latch = 1'b1;
			end
		end else if (final_end) begin
			if (above) begin
				nxt_s.high_flag = 1'b1;
			end else if (below) begin
				nxt_s.high_flag = 1'b0;
			end
		end
		if (nxt_s.cfg.hysteresis_mode_select) begin
			nxt_s.low_flag = 1'b0;
			nxt_s.alert_latch = 1'b0;
		end

		// Alert pin
		if (nxt_s.cfg.ready_to_pin_select) begin
			active = nxt_s.data_ready;
		end else if (nxt_s.cfg.hysteresis_mode_select) begin
			active = nxt_s.high_flag;
		end else begin
			active = nxt_s.alert_latch;
		end
		nxt_s.alert_pin = nxt_s.cfg.alert_polarity_bit ? active : ~active;
		nxt_s.frontend_on = (nxt_s.phase == PH_CONVERT);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			s_ff <= rst_s;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence seq_shut_wr;
		cfg_wr && (wcfg.conversion_mode_field == MODE_SHUT);
	endsequence

	sequence seq_single_done;
		final_end && s_ff.single_shot && !cfg_wr;
	endsequence

	a_shut_abort: assert property (seq_shut_wr |=> s_ff.phase == PH_SHUTDOWN && !o_frontend_on)
		else $error("shutdown write did not abort");
	a_single_return: assert property (seq_single_done |=> s_ff.phase == PH_SHUTDOWN
		&& s_ff.cfg.conversion_mode_field == MODE_SHUT && s_ff.data_ready)
		else $error("single shot did not return to shutdown");
	a_single_nostby: assert property (s_ff.single_shot |-> s_ff.phase != PH_STANDBY)
		else $error("single shot entered standby");
	a_result_load: assert property (final_end && !cfg_wr |=> s_ff.result == $past(avg_val))
		else $error("result not loaded at conversion end");
	a_ready_clear: assert property ((cfg_rd || res_rd) && !final_end |=> !s_ff.data_ready)
		else $error("read did not clear ready");
	a_win_set_wins: assert property (final_end && above && !s_ff.cfg.hysteresis_mode_select
		&& !cfg_wr |=> s_ff.high_flag)
		else $error("high flag not set");
	a_hyst_low_zero: assert property (s_ff.cfg.hysteresis_mode_select |-> !s_ff.low_flag)
		else $error("low flag set in hysteresis mode");
	a_hyst_read_keep: assert property (s_ff.cfg.hysteresis_mode_select && !final_end && !cfg_wr
		|=> $stable(s_ff.high_flag))
		else $error("high flag moved outside conversion end");
	a_pin_level: assert property (!cfg_wr && !s_ff.cfg.ready_to_pin_select
		&& s_ff.cfg.hysteresis_mode_select |=> o_alert == (s_ff.high_flag ~^ s_ff.cfg.alert_polarity_bit))
		else $error("alert pin does not track high flag");
	a_ready_pin: assert property (s_ff.cfg.ready_to_pin_select
		|-> o_alert == (s_ff.data_ready ~^ s_ff.cfg.alert_polarity_bit))
		else $error("alert pin does not show ready");
	a_win_resp_clr: assert property (i_alert_resp && !final_end && !cfg_wr && !s_ff.cfg.hysteresis_mode_select
		&& !s_ff.cfg.ready_to_pin_select |=> o_alert == ~s_ff.cfg.alert_polarity_bit)
		else $error("alert response did not release pin");

endmodule

`default_nettype wire

// >>> verif/tcma_frontend_model.sv
// Analog front end model feeding raw temperature samples
`timescale 1ns/1ps
`default_nettype none

module tcma_frontend_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_on,
	input  wire logic [15:0] i_value,
	output logic      [15:0] o_temp_code
);
	logic [15:0] junk_ff = 16'h5a5a;

	// ************************************************************
	// Powered-down front end shows a moving pattern
	// ************************************************************
	always @(posedge i_ref_clk) begin
		junk_ff <= junk_ff + 16'h1357;
	end

	assign o_temp_code = i_on ? i_value : junk_ff;
endmodule

`default_nettype wire

// >>> verif/tcma_core_tb.sv
// Testbench for the conversion mode and limit alert logic
`timescale 1ns/1ps
`default_nettype none

module tcma_core_tb;
	import tcma_pkg::*;
	localparam int CYCLE_TIME_FIELD = 20;
	localparam int STEP = 10;
	logic        ref_clk;
	logic        rst;
	tcma_bus_t   bus;
	tcma_cfg_t   por_cfg;
	logic [15:0] temp_value;
	logic [15:0] temp_code;
	logic        alert_resp;
	logic [15:0] rdata;
	logic        alert;
	logic        frontend_on;
	int          miscompares;
	int          compares;
	int          cycles;
	int          n;
	logic [1:0]  m;

	tcma_core #(.CYCLE_TIME_FIELD_CYC(CYCLE_TIME_FIELD), .STEP_CYC(STEP)) tcma_core_inst (
		.i_ref_clk(ref_clk), .i_rst(rst), .i_bus(bus), .i_por_cfg(por_cfg),
		.i_temp_code(temp_code), .i_alert_resp(alert_resp), .o_rdata(rdata),
		.o_alert(alert), .o_frontend_on(frontend_on));

	tcma_frontend_model tcma_frontend_model_inst (
		.i_ref_clk(ref_clk), .i_on(frontend_on), .i_value(temp_value),
		.o_temp_code(temp_code));

	// ************************************************************
	// Helpers
	// ************************************************************
	always #5 ref_clk = ~ref_clk;

	function automatic logic [15:0] cfgw(input logic [1:0] md, input logic [2:0] c,
		input logic [1:0] a, input logic h, input logic p, input logic d);
		cfgw = {4'h0, md, c, a, h, p, d, 2'h0};
	endfunction

	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	task automatic chk_alert(input logic exp);
		chk({15'h0, alert}, {15'h0, exp});
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic resp();
		@(posedge ref_clk);
		alert_resp <= 1'b1;
		@(posedge ref_clk);
		alert_resp <= 1'b0;
		tick();
	endtask

	task automatic shot(input logic [15:0] cfg, input logic [15:0] t, input int samples);
		int k;
		k = 0;
		temp_value <= t;
		bus_wr(REG_CONFIG, cfg);
		repeat (samples * CYCLE_TIME_FIELD + 20) begin
			tick();
			if (frontend_on === 1'b1) k++;
		end
		chk((k >= samples * CYCLE_TIME_FIELD - 1 && k <= samples * CYCLE_TIME_FIELD + 1) ? 16'h1 : 16'h0, 16'h1);
		chk({15'h0, frontend_on}, 16'h0);
	endtask

	task automatic wait_alert();
		n = 0;
		while (alert !== 1'b1 && n < 100) begin
			tick();
			n++;
		end
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		bus = '0;
		por_cfg = tcma_cfg_t'(10'h103);
		temp_value = 16'h0;
		alert_resp = 1'b0;
		miscompares = 0;
		compares = 0;
		cycles = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rd_chk(REG_CONFIG, cfgw(MODE_SHUT, 3'h0, 2'h0, 1'b0, 1'b1, 1'b0));
		rd_chk(REG_RESULT, RESULT_RST);
		rd_chk(8'h07, 16'h0);
		chk({14'h0, alert, frontend_on}, 16'h0);
		$display("test startup done");
		bus_wr(REG_HIGH, 16'h0100);
		bus_wr(REG_LOW, 16'hff00);
		shot(cfgw(MODE_SINGLE, 3'h7, 2'h0, 1'b0, 1'b1, 1'b0), 16'h0200, 1);
		chk_alert(1'b1);
		rd_chk(REG_RESULT, 16'h0200);
		rd_chk(REG_CONFIG, 16'h8000 | cfgw(MODE_SHUT, 3'h7, 2'h0, 1'b0, 1'b1, 1'b0));
		tick();
		chk_alert(1'b0);
		rd_chk(REG_CONFIG, cfgw(MODE_SHUT, 3'h7, 2'h0, 1'b0, 1'b1, 1'b0));
		shot(cfgw(MODE_SINGLE, 3'h0, 2'h1, 1'b0, 1'b0, 1'b0), 16'hfe00, 8);
		chk_alert(1'b0);
		resp();
		chk_alert(1'b1);
		rd_chk(REG_CONFIG, 16'h6000 | cfgw(MODE_SHUT, 3'h0, 2'h1, 1'b0, 1'b0, 1'b0));
		$display("test window done");
		shot(cfgw(MODE_SINGLE, 3'h0, 2'h0, 1'b1, 1'b1, 1'b0), 16'h0200, 1);
		resp();
		rd_chk(REG_CONFIG, 16'ha000 | cfgw(MODE_SHUT, 3'h0, 2'h0, 1'b1, 1'b1, 1'b0));
		rd_chk(REG_CONFIG, 16'h8000 | cfgw(MODE_SHUT, 3'h0, 2'h0, 1'b1, 1'b1, 1'b0));
		chk_alert(1'b1);
		shot(cfgw(MODE_SINGLE, 3'h0, 2'h0, 1'b1, 1'b1, 1'b0), 16'h0000, 1);
		chk_alert(1'b1);
		shot(cfgw(MODE_SINGLE, 3'h0, 2'h0, 1'b1, 1'b1, 1'b0), 16'hfe00, 1);
		chk_alert(1'b0);
		rd_chk(REG_CONFIG, 16'h2000 | cfgw(MODE_SHUT, 3'h0, 2'h0, 1'b1, 1'b1, 1'b0));
		$display("test hysteresis done");
		for (int i = 0; i < 2; i++) begin
			m = (i == 0) ? MODE_CONT_A : MODE_CONT_B;
			temp_value <= 16'h0300 + {14'h0, m};
			bus_wr(REG_CONFIG, cfgw(m, 3'h0, 2'h0, 1'b0, 1'b1, 1'b1));
			wait_alert();
			rd_chk(REG_RESULT, 16'h0300 + {14'h0, m});
			tick();
			chk_alert(1'b0);
			wait_alert();
			chk({14'h0, alert, frontend_on}, 16'h3);
			rd_chk(REG_RESULT, 16'h0300 + {14'h0, m});
		end
		bus_wr(REG_CONFIG, cfgw(MODE_SHUT, 3'h0, 2'h0, 1'b0, 1'b1, 1'b1));
		tick();
		chk({15'h0, frontend_on}, 16'h0);
		$display("test continuous done");
		summarize();
	end
endmodule

`default_nettype wire
